// *** core/ccr_pkg.sv ***
// Constants, register map and carrier types for comparator control regs.
// Assumes an AXI4-Lite master with 32-bit data and byte addresses.
package ccr_pkg;

  localparam int unsigned AXI_AW = 12;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_EVT  = 8'hBF;
  localparam logic [7:0] IDX_CTL1 = 8'hC1;
  localparam logic [7:0] IDX_CTL2 = 8'hC2;
  localparam logic [7:0] IDX_CTL3 = 8'hC3;
  localparam logic [7:0] IDX_CTL4 = 8'hC4;

  // Field positions
  localparam int unsigned BIT_ON    = 7;
  localparam int unsigned BIT_HYS   = 6;
  localparam int unsigned REF_MSB   = 5;
  localparam int unsigned DB_MSB    = 4;
  localparam int unsigned EN_LSB    = 4;
  localparam int unsigned FLAG_LSB  = 0;
  localparam int unsigned NUM_EVT   = 4;

  // Writable bits per register
  localparam logic [7:0] MASK_CTL1 = 8'hDF;
  localparam logic [7:0] MASK_CTL23 = 8'hFF;
  localparam logic [7:0] MASK_CTL4 = 8'hC0;

  // Reset values
  localparam logic [7:0] RST_CTL = 8'h00;
  localparam logic [7:0] RST_EVT = 8'h00;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic              awvalid;
    logic [AXI_AW-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [AXI_AW-1:0] araddr;
    logic              rready;
  } ccr_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ccr_axi_rsp_t;

  typedef struct packed {
    logic              aw_held;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_held;
    logic [7:0]        w_data;
    logic              w_lane0;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        ctl1;
    logic [7:0]        ctl2;
    logic [7:0]        ctl3;
    logic [7:0]        ctl4;
    logic [7:0]        evt;
    logic              filt;
    logic [4:0]        db_cnt;
  } ccr_state_t;

endpackage : ccr_pkg

// *** core/ccr_regs.sv ***
// Register bank for the comparator enables, references, debounce and
// qualified-event interrupts. Assumes a 50 MHz clk, an AXI4-Lite master,
// a one-cycle pulse_generator tick and one-cycle qualified event pulses.
//
// How it works
// - Per-comparator event enable gates its request.
// - Hardware sets event flags, bits 0 to 3.
// - Writing zero clears a flag; all reset zero.
// - Bit 7 turns each comparator on.
// - Bit 6 enables hysteresis; resets to zero.
// - Debounce time is field times pulse period; bypassed outside sync mode.
// - Zero field bypasses raw output unfiltered.
// - Six-bit reference code, bits 5 to 0.
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module ccr_regs #(
  parameter int unsigned NUM_QEVT = 4
) (
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire ccr_pkg::ccr_axi_req_t axi_req,
  output ccr_pkg::ccr_axi_rsp_t      axi_rsp,
  input  wire logic [3:0]           qual_event,
  input  wire logic                 cmp1_raw,
  input  wire logic                 pg_tick,
  input  wire logic                 pg_sync_mode,
  output logic      [3:0]           comp_on,
  output logic      [3:0]           hyst_on,
  output logic      [5:0]           ref_code_two,
  output logic      [5:0]           ref_code_three,
  output logic                      cmp1_out,
  output logic      [3:0]           qual_irq_req
);

  ////////////////////////////////////////////////////////////////////////
  // Parameter check

  if (NUM_QEVT != ccr_pkg::NUM_EVT) begin : g_bad_num
    $error("NUM_QEVT must equal four");
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  function automatic logic [8:0] reg_idx(
    input logic [ccr_pkg::AXI_AW-1:0] addr
  );
    logic ok;
    ok = (addr[1:0] == 2'h0) && (addr[ccr_pkg::AXI_AW-1:10] == 2'h0);
    reg_idx = {ok, addr[9:2]};
  endfunction : reg_idx

  function automatic logic mapped(input logic [8:0] ix);
    mapped = ix[8] && (ix[7:0] == ccr_pkg::IDX_EVT ||
      ix[7:0] == ccr_pkg::IDX_CTL1 || ix[7:0] == ccr_pkg::IDX_CTL2 ||
      ix[7:0] == ccr_pkg::IDX_CTL3 || ix[7:0] == ccr_pkg::IDX_CTL4);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////////////
  // State

  ccr_pkg::ccr_state_t s_q;
  ccr_pkg::ccr_state_t s_d;

  logic [8:0] wr_ix;
  logic [8:0] rd_ix;
  logic       do_wr;
  logic       do_rd;
  logic       wr_ok;
  logic       bypass;
  logic [4:0] db_len;
  logic [7:0] rd_val;
  logic [3:0] flags_kept;

  assign wr_ix  = reg_idx(s_q.aw_addr);
  assign rd_ix  = reg_idx(axi_req.araddr);
  assign do_wr  = s_q.aw_held && s_q.w_held && !s_q.bvalid;
  assign do_rd  = axi_req.arvalid && !s_q.rvalid;
  assign wr_ok  = do_wr && mapped(wr_ix) && s_q.w_lane0;
  assign db_len = s_q.ctl1[ccr_pkg::DB_MSB:0];
  assign bypass = (db_len == 5'h00) || !pg_sync_mode;

  ////////////////////////////////////////////////////////////////////////
  // Read mux

  always_comb begin
    rd_val = 8'h00;
    unique case (rd_ix[7:0])
      ccr_pkg::IDX_EVT:  rd_val = s_q.evt;
      ccr_pkg::IDX_CTL1: rd_val = s_q.ctl1;
      ccr_pkg::IDX_CTL2: rd_val = s_q.ctl2;
      ccr_pkg::IDX_CTL3: rd_val = s_q.ctl3;
      ccr_pkg::IDX_CTL4: rd_val = s_q.ctl4;
      default:           rd_val = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    flags_kept = s_q.evt[3:0];

    // Write address and data taken in either order
    if (axi_req.awvalid && !s_q.aw_held && !s_q.bvalid) begin
      s_d.aw_held = 1'b1;
      s_d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !s_q.w_held && !s_q.bvalid) begin
      s_d.w_held  = 1'b1;
      s_d.w_data  = axi_req.wdata[7:0];
      s_d.w_lane0 = axi_req.wstrb[0];
    end

    if (do_wr) begin
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = mapped(wr_ix) ? ccr_pkg::RESP_OKAY
                                  : ccr_pkg::RESP_SLVERR;
    end else if (s_q.bvalid && axi_req.bready) begin
      s_d.bvalid = 1'b0;
    end

    if (wr_ok) begin
      unique case (wr_ix[7:0])
        ccr_pkg::IDX_CTL1: s_d.ctl1 = s_q.w_data & ccr_pkg::MASK_CTL1;
        ccr_pkg::IDX_CTL2: s_d.ctl2 = s_q.w_data & ccr_pkg::MASK_CTL23;
        ccr_pkg::IDX_CTL3: s_d.ctl3 = s_q.w_data & ccr_pkg::MASK_CTL23;
        ccr_pkg::IDX_CTL4: s_d.ctl4 = s_q.w_data & ccr_pkg::MASK_CTL4;
        ccr_pkg::IDX_EVT: begin
          s_d.evt[7:4] = s_q.w_data[7:4];
          flags_kept   = s_q.evt[3:0] & s_q.w_data[3:0];
        end
        default: ;
      endcase
    end
    // Hardware set wins over a clearing write
    s_d.evt[3:0] = flags_kept | qual_event;

    // Read channel
    if (do_rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata  = mapped(rd_ix) ? {24'h000000, rd_val} : 32'h0000_0000;
      s_d.rresp  = mapped(rd_ix) ? ccr_pkg::RESP_OKAY
                                 : ccr_pkg::RESP_SLVERR;
    end else if (s_q.rvalid && axi_req.rready) begin
      s_d.rvalid = 1'b0;
    end

    // Debounce of comparator 1
    if (bypass) begin
      s_d.filt   = cmp1_raw;
      s_d.db_cnt = 5'h00;
    end else if (cmp1_raw == s_q.filt) begin
      s_d.db_cnt = 5'h00;
    end else if (pg_tick) begin
      if (5'(s_q.db_cnt + 5'h01) >= db_len) begin
        s_d.filt   = cmp1_raw;
        s_d.db_cnt = 5'h00;
      end else begin
        s_d.db_cnt = 5'(s_q.db_cnt + 5'h01);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q        <= '0;
      s_q.ctl1   <= ccr_pkg::RST_CTL;
      s_q.ctl2   <= ccr_pkg::RST_CTL;
      s_q.ctl3   <= ccr_pkg::RST_CTL;
      s_q.ctl4   <= ccr_pkg::RST_CTL;
      s_q.evt    <= ccr_pkg::RST_EVT;
      s_q.bresp  <= ccr_pkg::RESP_OKAY;
      s_q.rresp  <= ccr_pkg::RESP_OKAY;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign axi_rsp.awready = !s_q.aw_held && !s_q.bvalid;
  assign axi_rsp.wready  = !s_q.w_held && !s_q.bvalid;
  assign axi_rsp.bvalid  = s_q.bvalid;
  assign axi_rsp.bresp   = s_q.bresp;
  assign axi_rsp.arready = !s_q.rvalid;
  assign axi_rsp.rvalid  = s_q.rvalid;
  assign axi_rsp.rdata   = s_q.rdata;
  assign axi_rsp.rresp   = s_q.rresp;

  assign comp_on = {s_q.ctl4[ccr_pkg::BIT_ON], s_q.ctl3[ccr_pkg::BIT_ON],
                    s_q.ctl2[ccr_pkg::BIT_ON], s_q.ctl1[ccr_pkg::BIT_ON]};
  assign hyst_on = {s_q.ctl4[ccr_pkg::BIT_HYS], s_q.ctl3[ccr_pkg::BIT_HYS],
                    s_q.ctl2[ccr_pkg::BIT_HYS], s_q.ctl1[ccr_pkg::BIT_HYS]};
  assign ref_code_two   = s_q.ctl2[ccr_pkg::REF_MSB:0];
  assign ref_code_three = s_q.ctl3[ccr_pkg::REF_MSB:0];
  assign cmp1_out       = bypass ? cmp1_raw : s_q.filt;
  assign qual_irq_req   = s_q.evt[7:4] & s_q.evt[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Checks

  logic wr_evt;
  logic wr_c1;
  logic wr_c2;
  assign wr_evt = wr_ok && wr_ix[7:0] == ccr_pkg::IDX_EVT;
  assign wr_c1  = wr_ok && wr_ix[7:0] == ccr_pkg::IDX_CTL1;
  assign wr_c2  = wr_ok && wr_ix[7:0] == ccr_pkg::IDX_CTL2;

  chk_irq_gate: assert property (
    @(posedge clk) disable iff (rst)
    qual_event[0] && s_q.evt[4] && !wr_evt |=> qual_irq_req[0])
    else $error("enabled event did not raise its request");

  chk_irq_block: assert property (
    @(posedge clk) disable iff (rst)
    !s_q.evt[7] |-> !qual_irq_req[3])
    else $error("disabled event raised a request");

  chk_flag_set: assert property (
    @(posedge clk) disable iff (rst)
    qual_event[2] |=> s_q.evt[2] && $stable(s_q.evt[6]) || $past(wr_evt))
    else $error("event did not set its flag");

  chk_flag_clear: assert property (
    @(posedge clk) disable iff (rst)
    wr_evt && !s_q.w_data[1] && !qual_event[1] |=> !s_q.evt[1])
    else $error("zero write did not clear flag");

  chk_flag_hold: assert property (
    @(posedge clk) disable iff (rst)
    !qual_event[0] && !s_q.evt[0] |=> !s_q.evt[0])
    else $error("flag set without an event");

  chk_on_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_c1 |=> comp_on[0] == $past(s_q.w_data[7]))
    else $error("enable bit not written");

  chk_hys_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_c2 |=> hyst_on[1] == $past(s_q.w_data[6]) && comp_on[1] ==
      $past(s_q.w_data[7]))
    else $error("hysteresis bit not written");

  chk_ref_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_c2 |=> ref_code_two == $past(s_q.w_data[5:0]))
    else $error("reference code not written");

  chk_db_bypass: assert property (
    @(posedge clk) disable iff (rst)
    db_len == 5'h00 |-> cmp1_out == cmp1_raw)
    else $error("zero debounce did not bypass");

  chk_db_tick: assert property (
    @(posedge clk) disable iff (rst)
    !bypass && !$past(bypass) && $changed(s_q.filt) |->
      $past(pg_tick) && $past(s_q.db_cnt) == 5'($past(db_len) - 5'h01))
    else $error("debounce forwarded early");

  chk_db_len: assert property (
    @(posedge clk) disable iff (rst)
    !bypass && cmp1_raw != s_q.filt |-> s_q.db_cnt < db_len)
    else $error("debounce count exceeded length");

  chk_ref3_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_ok && wr_ix[7:0] == ccr_pkg::IDX_CTL3 |=>
      ref_code_three == $past(s_q.w_data[5:0]))
    else $error("reference code three not written");

  chk_ctl4_mask: assert property (
    @(posedge clk) disable iff (rst)
    wr_ok && wr_ix[7:0] == ccr_pkg::IDX_CTL4 |=>
      s_q.ctl4[5:0] == 6'h00 && hyst_on[3] == $past(s_q.w_data[6]))
    else $error("control four hysteresis not written");

  chk_db_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_c1 |=> db_len == $past(s_q.w_data[4:0]))
    else $error("debounce count not written");

  chk_db_hold: assert property (
    @(posedge clk) disable iff (rst)
    !$past(bypass) && $past(cmp1_raw == s_q.filt) |-> $stable(s_q.filt))
    else $error("debounce moved on a steady level");

  chk_flag_keep: assert property (
    @(posedge clk) disable iff (rst)
    wr_evt && s_q.w_data[2] && s_q.evt[2] |=> s_q.evt[2])
    else $error("one written to a flag cleared it");

  chk_en_write: assert property (
    @(posedge clk) disable iff (rst)
    wr_evt |=> s_q.evt[7:4] == $past(s_q.w_data[7:4]))
    else $error("event enables not written");

  chk_reset_clear: assert property (
    @(posedge clk) disable iff (rst)
    $fell(rst) |-> s_q.evt == 8'h00 && comp_on == 4'h0 && hyst_on == 4'h0)
    else $error("state not cleared by reset");

endmodule : ccr_regs

`default_nettype wire

// *** verification/ccr_front_model.sv ***
// Behavioural comparator front ends and pulse generator.
// Assumes the bench commands event pulses and the comparator 1 level.
`timescale 1ns/1ps
`default_nettype none
module ccr_front_model #(
  parameter int unsigned PG_PER = 5
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] ev_cmd,
  input  wire logic       lvl_cmd,
  output logic      [3:0] qual_event,
  output logic            cmp1_raw,
  output logic            pg_tick
);
  int unsigned cnt_q;
  ////////////////////////////////////////////////////////////////////////
  // Pulse generator period, one tick per period
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 0;
    end else begin
      cnt_q <= (cnt_q == PG_PER - 1) ? 0 : cnt_q + 1;
    end
  end
  assign pg_tick    = (cnt_q == PG_PER - 1);
  assign qual_event = ev_cmd;
  assign cmp1_raw   = lvl_cmd;
endmodule : ccr_front_model
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the comparator control register bank.
// Assumes the front model beside the design and a 50 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  clk;
  logic                  rst;
  logic                  sm;
  logic                  lvl_cmd;
  logic                  cmp1_raw;
  logic                  pg_tick;
  logic                  cmp1_out;
  ccr_pkg::ccr_axi_req_t req;
  ccr_pkg::ccr_axi_rsp_t rsp;
  logic [3:0]            ev_cmd;
  logic [3:0]            qual_event;
  logic [3:0]            comp_on;
  logic [3:0]            hyst_on;
  logic [3:0]            irq;
  logic [5:0]            ref2;
  logic [5:0]            ref3;
  int                    n_fail;
  int                    tests_run;
  localparam logic [1:0] OK = ccr_pkg::RESP_OKAY;
  localparam logic [1:0] ER = ccr_pkg::RESP_SLVERR;

  ccr_regs dut_u (.clk(clk), .rst(rst), .axi_req(req), .axi_rsp(rsp),
    .qual_event(qual_event), .cmp1_raw(cmp1_raw), .pg_tick(pg_tick),
    .pg_sync_mode(sm), .comp_on(comp_on), .hyst_on(hyst_on),
    .ref_code_two(ref2), .ref_code_three(ref3), .cmp1_out(cmp1_out),
    .qual_irq_req(irq));
  ccr_front_model fm_u (.clk(clk), .rst(rst), .ev_cmd(ev_cmd),
    .lvl_cmd(lvl_cmd), .qual_event(qual_event), .cmp1_raw(cmp1_raw),
    .pg_tick(pg_tick));

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [11:0] ba(input logic [7:0] x);
    return {2'b00, x, 2'b00};
  endfunction : ba

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : results

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int   i;
    logic ha;
    logic hw;
    logic bv;
    logic [1:0] r;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= {24'h0, d};
    req.wstrb   <= 4'hF;
    req.bready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk);
      ha = rsp.awready && req.awvalid;
      hw = rsp.wready && req.wvalid;
      bv = rsp.bvalid;
      r  = rsp.bresp;
      @(posedge clk);
      if (ha) req.awvalid <= 1'b0;
      if (hw) req.wvalid <= 1'b0;
      if (bv) break;
    end
    req.bready <= 1'b0;
    if (i == 50) begin
      n_fail++;
      results();
    end else begin
      chk({32'h0, r}, {32'h0, er});
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e,
                    input logic [1:0] er);
    int   i;
    logic ha;
    logic bv;
    logic [33:0] v;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge clk);
      ha = rsp.arready && req.arvalid;
      bv = rsp.rvalid;
      v  = {rsp.rresp, rsp.rdata};
      @(posedge clk);
      if (ha) req.arvalid <= 1'b0;
      if (bv) break;
    end
    req.rready <= 1'b0;
    if (i == 50) begin
      n_fail++;
      results();
    end else begin
      chk(v, {er, 24'h0, e});
    end
  endtask : rd

  ////////////////////////////////////////////////////////////////////////
  // Clock and test sequence
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    int n;
    int i;
    rst = 1'b1;
    req = '0;
    ev_cmd = 4'h0;
    lvl_cmd = 1'b0;
    sm = 1'b1;
    n_fail = 0;
    tests_run = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd(ba(ccr_pkg::IDX_EVT), 8'h00, OK);
    rd(ba(ccr_pkg::IDX_CTL1), 8'h00, OK);
    rd(ba(ccr_pkg::IDX_CTL2), 8'h00, OK);
    rd(ba(ccr_pkg::IDX_CTL3), 8'h00, OK);
    rd(ba(ccr_pkg::IDX_CTL4), 8'h00, OK);
    wr(ba(ccr_pkg::IDX_CTL2), 8'hFF, OK);
    rd(ba(ccr_pkg::IDX_CTL2), 8'hFF, OK);
    wr(ba(ccr_pkg::IDX_CTL3), 8'h95, OK);
    rd(ba(ccr_pkg::IDX_CTL3), 8'h95, OK);
    wr(ba(ccr_pkg::IDX_CTL1), 8'hE0, OK);
    rd(ba(ccr_pkg::IDX_CTL1), 8'hC0, OK);
    @(negedge clk);
    chk({ref3, ref2}, 12'h57F);
    chk({hyst_on, comp_on}, 8'h37);
    // Zero count passes the raw level straight through
    @(posedge clk) lvl_cmd <= 1'b1;
    @(negedge clk) chk(cmp1_out, 1'b1);
    @(posedge clk) lvl_cmd <= 1'b0;
    @(negedge clk) chk(cmp1_out, 1'b0);
    wr(ba(ccr_pkg::IDX_CTL1), 8'hC3, OK);
    @(posedge clk) lvl_cmd <= 1'b1;
    n = 0;
    for (i = 0; i < 99 && n < 3; i++) begin
      @(negedge clk);
      if (pg_tick) n++;
    end
    chk(n, 3);
    chk(cmp1_out, 1'b0);
    @(negedge clk) chk(cmp1_out, 1'b1);
    // Flags with enables off, then on, then cleared
    @(posedge clk) ev_cmd <= 4'h4;
    @(posedge clk) ev_cmd <= 4'h0;
    rd(ba(ccr_pkg::IDX_EVT), 8'h04, OK);
    @(negedge clk) chk(irq, 4'h0);
    wr(ba(ccr_pkg::IDX_EVT), 8'hF4, OK);
    @(negedge clk) chk(irq, 4'h4);
    @(posedge clk) ev_cmd <= 4'hF;
    @(posedge clk) ev_cmd <= 4'h0;
    rd(ba(ccr_pkg::IDX_EVT), 8'hFF, OK);
    wr(ba(ccr_pkg::IDX_EVT), 8'hF5, OK);
    rd(ba(ccr_pkg::IDX_EVT), 8'hF5, OK);
    @(negedge clk) chk(irq, 4'h5);
    wr(ba(ccr_pkg::IDX_EVT), 8'h05, OK);
    @(negedge clk) chk(irq, 4'h0);
    rd(12'h000, 8'h00, ER);
    wr(12'h000, 8'hFF, ER);
    // Control four keeps only its top two bits
    wr(ba(ccr_pkg::IDX_CTL4), 8'hFF, OK);
    rd(ba(ccr_pkg::IDX_CTL4), 8'hC0, OK);
    @(negedge clk) chk({hyst_on, comp_on}, 8'hBF);
    // Outside sync mode the raw level passes at once
    @(posedge clk) sm <= 1'b0;
    lvl_cmd <= 1'b0;
    @(negedge clk) chk(cmp1_out, 1'b0);
    // Reset in mid-run clears everything again
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(ba(ccr_pkg::IDX_CTL4), 8'h00, OK);
    rd(ba(ccr_pkg::IDX_EVT), 8'h00, OK);
    @(negedge clk) chk({ref3, ref2, hyst_on, comp_on}, 20'h00000);
    results();
  end
endmodule : testbench
`default_nettype wire
